/* File: logic/pbm_pkg.sv */
// Purpose: constants for the port basic mode control register bank
// Assumes: 50 MHz clock, APB with 32-bit data, byte addresses
// Notes: one register word per address, narrow data in the low bits
package pbm_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;

  // register byte addresses
  localparam logic [7:0] BASIC_MODE_CONTROL_ADDR = 8'h00;
  localparam logic [7:0] EVENT_STATUS_ADDR = 8'h04;

  // basic_mode_control fields
  localparam int BMC_SW_RESET = 15;
  localparam int BMC_LOOPBACK = 14;
  localparam int BMC_SPEED_100 = 13;
  localparam int BMC_AUTONEG_EN = 12;
  localparam int BMC_FULL_DUPLEX = 8;
  localparam logic [15:0] BMC_RESET_VAL = 16'h0000;

  // event_status fields
  localparam int EVS_CLEAR_UPON_READ = 0;
  localparam int EVS_LATCHED_LOW_HOLD = 1;
  localparam int EVS_LATCHED_HIGH_HOLD = 2;
  localparam int EVS_SELF_SET = 3;
  localparam int EVS_FIXED_READONLY = 4;
  localparam int EVS_EFF_DUPLEX = 8;
  localparam int EVS_EFF_SPEED = 13;
  localparam logic EVS_FIXED_VAL = 1'b1;

  // software reset duration
  localparam int CLK_FREQ_MHZ = 50;
  localparam int SWRST_TIME_NS = 1000;
  localparam int SWRST_CYCLES = (SWRST_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int SWRST_CNT_W = 6;
endpackage : pbm_pkg

/* File: logic/pbm_basic_mode_control.sv */
// Purpose: basic mode control register of one 10/100 port, plus a status word showing the
//          clear-upon-read, latched-low, latched-high, self-set and fixed read-only bit kinds
// Assumes: APB slave, all inputs synchronous to CLK, one wait state on every access
// Notes: bits 11..9 and 7..0 other than duplex are outside this block and read as zero
//
// Functional notes
// - a latched-low bit drops to zero on its event and stays zero until the register is read.
// - a latched-high bit rises to one on its event and stays one until the register is read.
// - a self-set bit is one while its event lasts and clears by itself once the event ends.
// - a fixed read-only bit always returns its default and ignores writes.
// - writing one to bit 15 starts a software reset that reads one until done, then self-clears.
// - when a software reset completes, all strap-derived values reload as at a hardware reset.
// - bit 14 set routes MII transmit data back onto the MII receive path; zero is normal.
// - with negotiation off, bit 13 forces speed, one for 100 Mb/s, zero for 10, strap default.
// - bit 12 enables negotiation, its reset value comes from a strap, software may rewrite it.
// - with negotiation on, speed and duplex bits are ignored; with it off they alone decide.
// - with negotiation off, bit 8 selects full duplex when one and half when zero, strap default.
`timescale 1ns/1ns
module pbm_basic_mode_control (
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [pbm_pkg::ADDR_W-1:0] PADDR,
  input wire logic [pbm_pkg::DATA_W-1:0] PWDATA,
  output logic [pbm_pkg::DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // straps
  input wire logic STRAP_SPEED_100,
  input wire logic STRAP_AUTONEG,
  input wire logic STRAP_FULL_DUPLEX,
  // negotiation result
  input wire logic AN_SPEED_100,
  input wire logic AN_FULL_DUPLEX,
  // status events
  input wire logic EVT_PULSE,
  input wire logic LINK_GOOD,
  input wire logic FAULT_SEEN,
  input wire logic EVT_ACTIVE,
  // mii data path
  input wire logic [3:0] MII_TXD,
  input wire logic MII_TX_EN,
  input wire logic [3:0] PHY_RXD,
  input wire logic PHY_RX_DV,
  output logic [3:0] MII_RXD,
  output logic MII_RX_DV,
  // port mode
  output logic PORT_SPEED_100,
  output logic PORT_FULL_DUPLEX,
  output logic PORT_AUTONEG_EN,
  output logic PORT_RESET_BUSY,
  output logic LOOPBACK_EN
);

  localparam int SWRST_LEN = pbm_pkg::SWRST_CYCLES;

  function automatic logic addr_is(input logic [pbm_pkg::ADDR_W-1:0] a, input logic [7:0] ref_a);
    addr_is = (a == ref_a);
  endfunction : addr_is

  // places one flag at its field position; shifting a single bit would lose it before widening
  function automatic logic [pbm_pkg::REG_W-1:0] bit_at(input logic b, input int pos);
    bit_at = '0;
    bit_at[pos] = b;
  endfunction : bit_at

  // control state
  logic rst_busy_q, rst_busy_d;
  logic [pbm_pkg::SWRST_CNT_W-1:0] rst_cnt_q, rst_cnt_d;
  logic strap_load_q, strap_load_d;
  logic lb_q, lb_d;
  logic spd_q, spd_d;
  logic an_q, an_d;
  logic dup_q, dup_d;
  // status state
  logic cor_q, ll_q, lh_q, sc_q;
  // bus state
  logic ack_q;
  logic [pbm_pkg::DATA_W-1:0] rdata_q, rdata_d;
  // port outputs
  logic eff_spd_q, eff_dup_q;
  logic [3:0] rxd_q;
  logic rx_dv_q;

  // bus decode: the first access cycle snapshots read data and applies read effects,
  // the second completes; the extra cycle keeps read data coming from a flip-flop
  wire access = PSEL & PENABLE;
  wire hit_bmc = addr_is(PADDR, pbm_pkg::BASIC_MODE_CONTROL_ADDR);
  wire hit_evs = addr_is(PADDR, pbm_pkg::EVENT_STATUS_ADDR);
  wire mapped = hit_bmc | hit_evs;
  wire snap = access & ~ack_q;
  wire rd_stat = snap & ~PWRITE & hit_evs;
  wire wr_done = access & ack_q & PWRITE;
  // writes are refused while a software reset runs, the restrap would override them anyway
  wire wr_bmc = wr_done & hit_bmc & ~rst_busy_q;
  wire rst_start = wr_bmc & PWDATA[pbm_pkg::BMC_SW_RESET];
  wire rst_end = rst_busy_q & (rst_cnt_q == pbm_pkg::SWRST_CNT_W'(SWRST_LEN - 1));

  wire [pbm_pkg::REG_W-1:0] bmc_view =
    bit_at(rst_busy_q, pbm_pkg::BMC_SW_RESET) | bit_at(lb_q, pbm_pkg::BMC_LOOPBACK) |
    bit_at(spd_q, pbm_pkg::BMC_SPEED_100) | bit_at(an_q, pbm_pkg::BMC_AUTONEG_EN) |
    bit_at(dup_q, pbm_pkg::BMC_FULL_DUPLEX);
  wire [pbm_pkg::REG_W-1:0] evs_view =
    bit_at(cor_q, pbm_pkg::EVS_CLEAR_UPON_READ) | bit_at(ll_q, pbm_pkg::EVS_LATCHED_LOW_HOLD) |
    bit_at(lh_q, pbm_pkg::EVS_LATCHED_HIGH_HOLD) | bit_at(sc_q, pbm_pkg::EVS_SELF_SET) |
    bit_at(pbm_pkg::EVS_FIXED_VAL, pbm_pkg::EVS_FIXED_READONLY) |
    bit_at(eff_dup_q, pbm_pkg::EVS_EFF_DUPLEX) | bit_at(eff_spd_q, pbm_pkg::EVS_EFF_SPEED);

  always_comb
  begin
    rdata_d = rdata_q;
    if (snap & ~PWRITE)
    begin
      rdata_d = '0;
      if (hit_bmc)
        rdata_d = pbm_pkg::DATA_W'(bmc_view);
      else if (hit_evs)
        rdata_d = pbm_pkg::DATA_W'(evs_view);
    end
  end

  // software reset sequencing and strap reload
  always_comb
  begin
    rst_busy_d = rst_busy_q;
    rst_cnt_d = rst_cnt_q;
    strap_load_d = 1'b0;
    if (rst_start)
    begin
      rst_busy_d = 1'b1;
      rst_cnt_d = '0;
    end
    else if (rst_end)
    begin
      rst_busy_d = 1'b0;
      strap_load_d = 1'b1;
    end
    else if (rst_busy_q)
      rst_cnt_d = rst_cnt_q + 1'b1;
  end

  always_comb
  begin
    lb_d = lb_q;
    spd_d = spd_q;
    an_d = an_q;
    dup_d = dup_q;
    if (strap_load_q)
    begin
      // straps are sampled one cycle after hardware reset release and after a software reset
      // limitation: a write completing in this cycle is lost to the reload
      lb_d = pbm_pkg::BMC_RESET_VAL[pbm_pkg::BMC_LOOPBACK];
      spd_d = STRAP_SPEED_100;
      an_d = STRAP_AUTONEG;
      dup_d = STRAP_FULL_DUPLEX;
    end
    else if (wr_bmc)
    begin
      lb_d = PWDATA[pbm_pkg::BMC_LOOPBACK];
      spd_d = PWDATA[pbm_pkg::BMC_SPEED_100];
      an_d = PWDATA[pbm_pkg::BMC_AUTONEG_EN];
      dup_d = PWDATA[pbm_pkg::BMC_FULL_DUPLEX];
    end
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      rst_busy_q <= 1'b0;
      rst_cnt_q <= '0;
      strap_load_q <= 1'b1;
      lb_q <= pbm_pkg::BMC_RESET_VAL[pbm_pkg::BMC_LOOPBACK];
      spd_q <= pbm_pkg::BMC_RESET_VAL[pbm_pkg::BMC_SPEED_100];
      an_q <= pbm_pkg::BMC_RESET_VAL[pbm_pkg::BMC_AUTONEG_EN];
      dup_q <= pbm_pkg::BMC_RESET_VAL[pbm_pkg::BMC_FULL_DUPLEX];
    end
    else
    begin
      rst_busy_q <= rst_busy_d;
      rst_cnt_q <= rst_cnt_d;
      strap_load_q <= strap_load_d;
      lb_q <= lb_d;
      spd_q <= spd_d;
      an_q <= an_d;
      dup_q <= dup_d;
    end
  end

  // status bits: a new event in the read cycle always survives the read
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      cor_q <= 1'b0;
      ll_q <= 1'b1;
      lh_q <= 1'b0;
      sc_q <= 1'b0;
    end
    else
    begin
      cor_q <= EVT_PULSE | (cor_q & ~rd_stat);
      ll_q <= rd_stat ? LINK_GOOD : (ll_q & LINK_GOOD);
      lh_q <= rd_stat ? FAULT_SEEN : (lh_q | FAULT_SEEN);
      sc_q <= EVT_ACTIVE;
    end
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      ack_q <= 1'b0;
      rdata_q <= '0;
    end
    else
    begin
      ack_q <= snap;
      rdata_q <= rdata_d;
    end
  end

  // port mode and mii receive mux
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      eff_spd_q <= 1'b0;
      eff_dup_q <= 1'b0;
      rxd_q <= '0;
      rx_dv_q <= 1'b0;
    end
    else
    begin
      eff_spd_q <= an_q ? AN_SPEED_100 : spd_q;
      eff_dup_q <= an_q ? AN_FULL_DUPLEX : dup_q;
      rxd_q <= lb_q ? MII_TXD : PHY_RXD;
      rx_dv_q <= lb_q ? MII_TX_EN : PHY_RX_DV;
    end
  end

  assign PREADY = ack_q;
  assign PSLVERR = ack_q & access & ~mapped;
  assign PRDATA = rdata_q;
  assign MII_RXD = rxd_q;
  assign MII_RX_DV = rx_dv_q;
  assign PORT_SPEED_100 = eff_spd_q;
  assign PORT_FULL_DUPLEX = eff_dup_q;
  assign PORT_AUTONEG_EN = an_q;
  assign PORT_RESET_BUSY = rst_busy_q;
  assign LOOPBACK_EN = lb_q;

  a_cor_read_clear: assert property (@(posedge CLK) disable iff (!NRST)
    rd_stat && !EVT_PULSE |=> !cor_q)
    else $error("clear-upon-read bit survived a read");
  a_cor_set_wins: assert property (@(posedge CLK) disable iff (!NRST)
    EVT_PULSE |=> cor_q)
    else $error("clear-upon-read event lost");
  a_ll_hold_low: assert property (@(posedge CLK) disable iff (!NRST)
    (!LINK_GOOD || (!ll_q && !rd_stat)) |=> !ll_q)
    else $error("latched-low bit released without a read");
  a_lh_hold_high: assert property (@(posedge CLK) disable iff (!NRST)
    (FAULT_SEEN || (lh_q && !rd_stat)) |=> lh_q)
    else $error("latched-high bit released without a read");
  a_self_set_follow: assert property (@(posedge CLK) disable iff (!NRST)
    ##1 sc_q == $past(EVT_ACTIVE))
    else $error("self-set bit does not follow its event");
  a_fixed_bit_read: assert property (@(posedge CLK) disable iff (!NRST)
    rd_stat |=> PRDATA[pbm_pkg::EVS_FIXED_READONLY] == pbm_pkg::EVS_FIXED_VAL)
    else $error("fixed read-only bit changed");
  a_swrst_length: assert property (@(posedge CLK) disable iff (!NRST)
    $rose(rst_busy_q) |-> rst_busy_q[*8] ##[1:SWRST_LEN] !rst_busy_q)
    else $error("software reset too short or never ends");
  a_swrst_restrap: assert property (@(posedge CLK) disable iff (!NRST)
    $fell(rst_busy_q) |=> spd_q == $past(STRAP_SPEED_100) && an_q == $past(STRAP_AUTONEG)
      && dup_q == $past(STRAP_FULL_DUPLEX) && !lb_q)
    else $error("straps not reloaded after software reset");
  a_loopback_path: assert property (@(posedge CLK) disable iff (!NRST)
    lb_q |=> MII_RXD == $past(MII_TXD) && MII_RX_DV == $past(MII_TX_EN))
    else $error("loopback does not return transmit data");
  a_forced_mode: assert property (@(posedge CLK) disable iff (!NRST)
    !an_q |=> PORT_SPEED_100 == $past(spd_q) && PORT_FULL_DUPLEX == $past(dup_q))
    else $error("forced speed or duplex not applied");
  a_an_override: assert property (@(posedge CLK) disable iff (!NRST)
    an_q |=> PORT_SPEED_100 == $past(AN_SPEED_100) && PORT_FULL_DUPLEX == $past(AN_FULL_DUPLEX))
    else $error("negotiation result not used while enabled");
  a_swrst_exact: assert property (@(posedge CLK) disable iff (!NRST)
    $rose(rst_busy_q) |-> ##SWRST_LEN $fell(rst_busy_q))
    else $error("software reset length differs from its count");
  a_swrst_reads_one: assert property (@(posedge CLK) disable iff (!NRST)
    snap && !PWRITE && hit_bmc && rst_busy_q |=> PRDATA[pbm_pkg::BMC_SW_RESET])
    else $error("reset bit does not read one while busy");
  a_cor_held: assert property (@(posedge CLK) disable iff (!NRST)
    cor_q && !rd_stat |=> cor_q)
    else $error("clear-upon-read bit lost without a read");
  a_ll_rearm: assert property (@(posedge CLK) disable iff (!NRST)
    rd_stat && LINK_GOOD |=> ll_q)
    else $error("latched-low bit not re-armed by a read");
  a_normal_path: assert property (@(posedge CLK) disable iff (!NRST)
    !lb_q |=> MII_RXD == $past(PHY_RXD) && MII_RX_DV == $past(PHY_RX_DV))
    else $error("receive path not normal without loopback");

endmodule : pbm_basic_mode_control

/* File: verif/pbm_mac_model.sv */
// Purpose: mac side transmit source facing the port
// Assumes: bench hands in a fresh random word every cycle
// Notes: idle while in reset so no stale nibble is looped back
`timescale 1ns/1ns
module pbm_mac_model (
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // random source
  input wire logic [31:0] RND,
  // mii transmit
  output logic [3:0] MII_TXD,
  output logic MII_TX_EN
);
  always @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      MII_TXD <= 4'h0;
      MII_TX_EN <= 1'b0;
    end
    else
    begin
      MII_TXD <= RND[11:8];
      MII_TX_EN <= RND[12];
    end
  end
endmodule : pbm_mac_model

/* File: verif/tb_top.sv */
// Purpose: self-checking bench for the port basic mode control bank
// Assumes: straps start at speed 100, full duplex, negotiation off, and change before the software reset
// Notes: read data is checked from a queue of expected words
`timescale 1ns/1ns
module tb_top;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, an_spd, an_dup;
  logic evt_p, link_ok, fault, evt_act, tx_en, phy_dv, rx_dv, spd, dup, an_en, busy, lb, mii_on, mii_lb;
  logic s_spd, s_an, s_dup;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic [3:0] txd, phy_rxd, rxd;
  logic [4:0] tx_p, rx_p;
  logic [64:0] e;
  logic [64:0] exp_q[$];
  int n_errors, num_checks, k, busy_n;
  pbm_basic_mode_control pbm_basic_mode_control_i (.CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .STRAP_SPEED_100(s_spd), .STRAP_AUTONEG(s_an), .STRAP_FULL_DUPLEX(s_dup), .AN_SPEED_100(an_spd),
    .AN_FULL_DUPLEX(an_dup), .EVT_PULSE(evt_p), .LINK_GOOD(link_ok), .FAULT_SEEN(fault), .EVT_ACTIVE(evt_act),
    .MII_TXD(txd), .MII_TX_EN(tx_en), .PHY_RXD(phy_rxd), .PHY_RX_DV(phy_dv), .MII_RXD(rxd), .MII_RX_DV(rx_dv),
    .PORT_SPEED_100(spd), .PORT_FULL_DUPLEX(dup), .PORT_AUTONEG_EN(an_en), .PORT_RESET_BUSY(busy),
    .LOOPBACK_EN(lb));
  pbm_mac_model pbm_mac_model_i (.CLK(clk), .NRST(nrst), .RND(rnd), .MII_TXD(txd), .MII_TX_EN(tx_en));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task tally_and_finish;
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] s);
    num_checks++;
    if (s !== ex)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, ex, s);
    end
  endtask : chk
  task mode(input logic s, input logic d, input logic a);
    chk("speed", {31'h0, s}, {31'h0, spd});
    chk("duplex", {31'h0, d}, {31'h0, dup});
    chk("autoneg", {31'h0, a}, {31'h0, an_en});
  endtask : mode
  // the expected word is queued here and judged by the monitor when pready comes
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [31:0] ed,
    input logic [31:0] m, input logic ee);
    int w;
    exp_q.push_back({ed, m, ee});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    w = 0;
    do
    begin
      @(posedge clk);
      w++;
    end
    while (pready !== 1'b1 && w < 20);
    if (w >= 20)
    begin
      n_errors++;
      tally_and_finish();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  always @(posedge clk)
  begin
    rnd <= lfsr(rnd);
    if (busy === 1'b1)
      busy_n++;
    phy_rxd <= rnd[3:0];
    phy_dv <= rnd[4];
    if (psel && penable && pready === 1'b1 && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      chk("prdata", e[64:33] & e[32:1], prdata & e[32:1]);
      chk("pslverr", {31'h0, e[0]}, {31'h0, pslverr});
    end
    if (mii_on)
      chk("mii_rx", {27'h0, mii_lb ? tx_p : rx_p}, {27'h0, rx_dv, rxd});
    tx_p <= {tx_en, txd};
    rx_p <= {phy_dv, phy_rxd};
  end
  initial
  begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    {nrst, psel, penable, pwrite, an_spd, an_dup, evt_p, fault, evt_act, mii_on, mii_lb} = '0;
    {paddr, pwdata} = '0;
    {phy_rxd, phy_dv, tx_p, rx_p} = '0;
    link_ok = 1'b1;
    {s_spd, s_an, s_dup} = 3'b101;
    busy_n = 0;
    rnd = 32'h5d32f6c6;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    apb(0, 8'h00, 0, 32'h2100, 32'hffffffff, 0);
    apb(0, 8'h04, 0, 32'h12, 32'h1f, 0);
    mode(1, 1, 0);
    apb(1, 8'h00, 32'h4000, 0, 0, 0);
    apb(0, 8'h00, 0, 32'h4000, 32'hffffffff, 0);
    mode(0, 0, 0);
    // no dead time on this registered path; the line side owns the descrambler wait
    mii_lb <= 1'b1;
    mii_on <= 1'b1;
    repeat (10) @(posedge clk);
    mii_on <= 1'b0;
    apb(1, 8'h00, 32'h0100, 0, 0, 0);
    @(posedge clk);
    mode(0, 1, 0);
    apb(1, 8'h00, 32'h3000, 0, 0, 0);
    mii_lb <= 1'b0;
    mii_on <= 1'b1;
    for (k = 0; k < 6; k++)
    begin
      an_spd <= rnd[5];
      an_dup <= rnd[6];
      repeat (3) @(posedge clk);
      mode(an_spd, an_dup, 1);
    end
    mii_on <= 1'b0;
    evt_p <= 1'b1;
    link_ok <= 1'b0;
    fault <= 1'b1;
    evt_act <= 1'b1;
    @(posedge clk);
    evt_p <= 1'b0;
    link_ok <= 1'b1;
    fault <= 1'b0;
    repeat (3) @(posedge clk);
    apb(0, 8'h04, 0, 32'h1d, 32'h1f, 0);
    apb(0, 8'h04, 0, 32'h1a, 32'h1f, 0);
    evt_act <= 1'b0;
    apb(1, 8'h04, 0, 0, 0, 0);
    apb(0, 8'h04, 0, 32'h12, 32'h1f, 0);
    apb(0, 8'h08, 0, 0, 32'hffffffff, 1);
    apb(1, 8'h08, 32'hffff, 0, 0, 1);
    // new negotiation and duplex strap levels differ from the bits of the reset write, so only a reload can show them
    s_spd <= 1'b0;
    s_an <= 1'b1;
    s_dup <= 1'b1;
    apb(1, 8'h00, 32'hc000, 0, 0, 0);
    chk("busy", 1, {31'h0, busy});
    apb(0, 8'h00, 0, 32'h8000, 32'h8000, 0);
    k = 0;
    while (busy === 1'b1 && k < 100)
    begin
      @(posedge clk);
      k++;
    end
    if (k >= 100)
    begin
      n_errors++;
      tally_and_finish();
    end
    chk("busy_len", pbm_pkg::SWRST_CYCLES, busy_n);
    repeat (3) @(posedge clk);
    apb(0, 8'h00, 0, 32'h1100, 32'hffffffff, 0);
    mode(an_spd, an_dup, 1);
    chk("loopback", 0, {31'h0, lb});
    tally_and_finish();
  end
endmodule : tb_top
